// ===== design/pxd_iir.sv
// Recursive blend: ((ONE - coef) * sample + coef * prev) / ONE.
// Purely combinational; the caller registers the result.
`timescale 1ns/1ps
`default_nettype none
module pxd_iir #(
  parameter int W = pxd_pkg::SAMPLE_W,
  parameter int CW = pxd_pkg::COEF_W
) (
  // Operands
  input wire logic [W-1:0] sample,
  input wire logic [W-1:0] prev,
  input wire logic [CW-1:0] coef,
  // Result
  output logic [W-1:0] result
);
  localparam int SW = W + CW + 1;
  localparam logic [CW:0] ONE = (CW+1)'(1 << CW);
  logic [CW:0] keep;
  logic [SW-1:0] acc;

  always_comb begin
    keep = ONE - {1'b0, coef};
    acc = SW'(keep) * SW'(sample) + SW'(coef) * SW'(prev);
    result = acc[W+CW-1:CW];
  end
endmodule
`default_nettype wire

// ===== design/pxd_pkg.sv
// Shared constants for the proximity digital processing block.
// Assumes a single 125 MHz clock and a 32-bit APB register port.
package pxd_pkg;
  localparam int SAMPLE_W = 12;
  localparam int COEF_W = 4;
  localparam int SCAN_W = 3;
  localparam int LIM_W = 8;
  localparam int CNT_W = 4;
  localparam int CLK_MHZ = 125;
  localparam int SCAN_UNIT_US = 1000;
  localparam int SCAN_UNIT_CYCLES = SCAN_UNIT_US * CLK_MHZ;

  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_FILT = 8'h04;
  localparam logic [7:0] ADDR_THR = 8'h08;
  localparam logic [7:0] ADDR_DRIFT = 8'h0C;
  localparam logic [7:0] ADDR_COMP = 8'h10;
  localparam logic [7:0] ADDR_STAT = 8'h14;
  localparam logic [7:0] ADDR_SAMP = 8'h18;
  localparam logic [7:0] ADDR_BASE = 8'h1C;

  localparam int CTRL_SCAN_LSB = 0;
  localparam int CTRL_IRQ_SEL = 3;
  localparam int CTRL_NEAR_EN = 4;
  localparam int CTRL_AWAY_EN = 5;
  localparam int CTRL_DONE_EN = 6;
  localparam int CTRL_CDONE_EN = 7;
  localparam int CTRL_COMP_REQ = 8;
  localparam int FILT_RAW_LSB = 0;
  localparam int FILT_POS_LSB = 4;
  localparam int FILT_NEG_LSB = 8;
  localparam int DR_POS_LIM_LSB = 0;
  localparam int DR_POS_DEB_LSB = 8;
  localparam int DR_NEG_LIM_LSB = 12;
  localparam int DR_NEG_DEB_LSB = 20;
  localparam int COMP_RATE_LSB = 0;
  localparam int COMP_STUCK_LSB = 4;

  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [11:0] FILT_RST = 12'h4C8;
  localparam logic [11:0] THR_RST = 12'h040;
  localparam logic [23:0] DRIFT_RST = 24'h320320;
  localparam logic [7:0] COMP_RST = 8'h00;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_GRANT = 3'h1,
    ST_COMP = 3'h2,
    ST_CONV = 3'h3,
    ST_FILT = 3'h4,
    ST_BASE = 3'h5,
    ST_DIFF = 3'h6,
    ST_STAT = 3'h7
  } pxd_state_type;
endpackage

// ===== design/pxd_prox_core.sv
// Proximity sequencing, filtering, compensation control, APB registers.
// AFE and ADC arbiter answer start/request with done/grant pulses or levels.
//
// Design decisions made here: the address map and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module pxd_prox_core #(
  parameter int SCAN_UNIT_CYCLES = pxd_pkg::SCAN_UNIT_CYCLES
) (
  // APB slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Touch sequencer
  input wire logic host_driven_mode,
  input wire logic touch_detect_mode,
  input wire logic touch_trigger_mode,
  input wire logic pen_contact,
  input wire logic convert_cmd,
  input wire logic chan_selected,
  output logic touch_conv_start,
  // ADC arbitration
  output logic adc_req,
  input wire logic adc_grant,
  // Analog front-end
  output logic afe_comp_start,
  output logic afe_conv_start,
  input wire logic afe_comp_done,
  input wire logic afe_conv_done,
  input wire logic [pxd_pkg::SAMPLE_W-1:0] afe_raw,
  // Events and status
  output logic near_irq,
  output logic away_irq,
  output logic op_done_irq,
  output logic comp_done_irq,
  output logic near_flag,
  output logic comp_pending_flag,
  output logic conversion_active_flag
);
  localparam int W = pxd_pkg::SAMPLE_W;
  localparam int CW = pxd_pkg::COEF_W;
  localparam int LW = pxd_pkg::LIM_W;
  localparam int NW = pxd_pkg::CNT_W;

  function automatic logic signed [W:0] sdiff(input logic [W-1:0] a, input logic [W-1:0] b);
    sdiff = $signed({1'b0, a}) - $signed({1'b0, b});
  endfunction

  function automatic logic addr_hit(input logic [7:0] a);
    addr_hit = a inside {pxd_pkg::ADDR_CTRL, pxd_pkg::ADDR_FILT, pxd_pkg::ADDR_THR,
      pxd_pkg::ADDR_DRIFT, pxd_pkg::ADDR_COMP, pxd_pkg::ADDR_STAT,
      pxd_pkg::ADDR_SAMP, pxd_pkg::ADDR_BASE};
  endfunction

  pxd_pkg::pxd_state_type state_r, state_nxt;
  logic [7:0] ctrl_r;
  logic [11:0] filt_r;
  logic [W-1:0] thr_r;
  logic [23:0] drift_r;
  logic [7:0] compcfg_r;
  logic [W-1:0] raw_cap_sample, filtered_cap_sample, env_baseline, baseline_ref_r;
  logic [W-1:0] filt_calc, base_calc;
  logic signed [W:0] user_delta, drift;
  logic [NW-1:0] pos_cnt_r, neg_cnt_r, per_cnt_r, stuck_cnt_r;
  logic comp_pend_r, reinit_r, touch_after_r, tick;
  logic wr_en, rd_setup, wr_ctrl, host_req, startup_req;
  logic drift_req, periodic_req, stuck_req, comp_fin, op_start, direct_touch;
  logic auto_mode, scan_on, near_nxt;
  logic [pxd_pkg::SCAN_W-1:0] scan_interval_setting;
  logic irq_source_select;
  logic [CW-1:0] raw_filter_coef, baseline_pos_coef, baseline_neg_coef;
  logic [LW-1:0] baseline_pos_drift_limit, baseline_neg_drift_limit;
  logic [NW-1:0] baseline_pos_debounce, baseline_neg_debounce;
  logic [NW-1:0] periodic_comp_rate, stuck_close_limit;

  assign scan_interval_setting = ctrl_r[pxd_pkg::CTRL_SCAN_LSB +: pxd_pkg::SCAN_W];
  assign irq_source_select = ctrl_r[pxd_pkg::CTRL_IRQ_SEL];
  assign raw_filter_coef = filt_r[pxd_pkg::FILT_RAW_LSB +: CW];
  assign baseline_pos_coef = filt_r[pxd_pkg::FILT_POS_LSB +: CW];
  assign baseline_neg_coef = filt_r[pxd_pkg::FILT_NEG_LSB +: CW];
  assign baseline_pos_drift_limit = drift_r[pxd_pkg::DR_POS_LIM_LSB +: LW];
  assign baseline_pos_debounce = drift_r[pxd_pkg::DR_POS_DEB_LSB +: NW];
  assign baseline_neg_drift_limit = drift_r[pxd_pkg::DR_NEG_LIM_LSB +: LW];
  assign baseline_neg_debounce = drift_r[pxd_pkg::DR_NEG_DEB_LSB +: NW];
  assign periodic_comp_rate = compcfg_r[pxd_pkg::COMP_RATE_LSB +: NW];
  assign stuck_close_limit = compcfg_r[pxd_pkg::COMP_STUCK_LSB +: NW];

  // Zero-wait slave; read data is captured in the setup phase
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addr_hit(paddr);
  assign wr_en = psel && penable && pwrite;
  assign rd_setup = psel && !penable && !pwrite;
  assign wr_ctrl = wr_en && paddr == pxd_pkg::ADDR_CTRL;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= pxd_pkg::CTRL_RST;
      filt_r <= pxd_pkg::FILT_RST;
      thr_r <= pxd_pkg::THR_RST;
      drift_r <= pxd_pkg::DRIFT_RST;
      compcfg_r <= pxd_pkg::COMP_RST;
    end else if (wr_en) begin
      case (paddr)
        pxd_pkg::ADDR_CTRL: ctrl_r <= pwdata[7:0];
        pxd_pkg::ADDR_FILT: filt_r <= pwdata[11:0];
        pxd_pkg::ADDR_THR: thr_r <= pwdata[W-1:0];
        pxd_pkg::ADDR_DRIFT: drift_r <= pwdata[23:0];
        pxd_pkg::ADDR_COMP: compcfg_r <= pwdata[7:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd_setup) begin
      case (paddr)
        pxd_pkg::ADDR_CTRL: prdata <= {24'h00_0000, ctrl_r};
        pxd_pkg::ADDR_FILT: prdata <= {20'h0_0000, filt_r};
        pxd_pkg::ADDR_THR: prdata <= {20'h0_0000, thr_r};
        pxd_pkg::ADDR_DRIFT: prdata <= {8'h00, drift_r};
        pxd_pkg::ADDR_COMP: prdata <= {24'h00_0000, compcfg_r};
        pxd_pkg::ADDR_STAT: prdata <= {29'h0000_0000, conversion_active_flag,
          comp_pending_flag, near_flag};
        pxd_pkg::ADDR_SAMP: prdata <= {4'h0, filtered_cap_sample, 4'h0, raw_cap_sample};
        pxd_pkg::ADDR_BASE: prdata <= {3'h0, user_delta, 4'h0, env_baseline};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  pxd_tick_gen #(
    .UNIT_CYCLES(SCAN_UNIT_CYCLES),
    .IW(pxd_pkg::SCAN_W)
  ) u_tick (
    .pclk(pclk),
    .presetn(presetn),
    .interval(scan_interval_setting),
    .tick(tick)
  );

  // Compensation request sources
  assign host_req = wr_ctrl && pwdata[pxd_pkg::CTRL_COMP_REQ];
  assign startup_req = wr_ctrl && scan_interval_setting == '0 &&
    pwdata[pxd_pkg::CTRL_SCAN_LSB +: pxd_pkg::SCAN_W] != '0;
  assign comp_fin = state_r == pxd_pkg::ST_COMP && afe_comp_done;

  // New requests win over the clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      comp_pend_r <= 1'b0;
    end else begin
      comp_pend_r <= (comp_pend_r && !comp_fin) || host_req || startup_req ||
        drift_req || periodic_req || stuck_req;
    end
  end

  // Sequencer: ticks are looked at only in idle
  assign scan_on = scan_interval_setting != '0;
  assign auto_mode = touch_detect_mode || touch_trigger_mode;
  assign op_start = scan_on && ((auto_mode && tick && !pen_contact) ||
    (host_driven_mode && convert_cmd && !chan_selected));
  assign direct_touch = host_driven_mode && convert_cmd && (chan_selected || !scan_on);

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      pxd_pkg::ST_IDLE: if (op_start) state_nxt = pxd_pkg::ST_GRANT;
      pxd_pkg::ST_GRANT: begin
        if (adc_grant) begin
          state_nxt = comp_pend_r ? pxd_pkg::ST_COMP : pxd_pkg::ST_CONV;
        end
      end
      pxd_pkg::ST_COMP: if (afe_comp_done) state_nxt = pxd_pkg::ST_CONV;
      pxd_pkg::ST_CONV: if (afe_conv_done) state_nxt = pxd_pkg::ST_FILT;
      pxd_pkg::ST_FILT: state_nxt = pxd_pkg::ST_BASE;
      pxd_pkg::ST_BASE: state_nxt = pxd_pkg::ST_DIFF;
      pxd_pkg::ST_DIFF: state_nxt = pxd_pkg::ST_STAT;
      pxd_pkg::ST_STAT: state_nxt = pxd_pkg::ST_IDLE;
      default: state_nxt = pxd_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= pxd_pkg::ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ADC held from grant request through the conversion
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      adc_req <= 1'b0;
      afe_comp_start <= 1'b0;
      afe_conv_start <= 1'b0;
      conversion_active_flag <= 1'b0;
    end else begin
      adc_req <= state_nxt inside {pxd_pkg::ST_GRANT, pxd_pkg::ST_COMP,
        pxd_pkg::ST_CONV};
      afe_comp_start <= state_r == pxd_pkg::ST_GRANT && adc_grant && comp_pend_r;
      afe_conv_start <= (state_r == pxd_pkg::ST_GRANT && adc_grant && !comp_pend_r) ||
        comp_fin;
      conversion_active_flag <= state_nxt != pxd_pkg::ST_IDLE;
    end
  end

  // Touch conversion follows the proximity op only with pen contact
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      touch_after_r <= 1'b0;
      touch_conv_start <= 1'b0;
    end else begin
      if (state_r == pxd_pkg::ST_IDLE && op_start) begin
        touch_after_r <= host_driven_mode && pen_contact;
      end
      touch_conv_start <= (state_r == pxd_pkg::ST_IDLE && direct_touch) ||
        (state_r == pxd_pkg::ST_STAT && touch_after_r);
    end
  end

  pxd_iir #(.W(W), .CW(CW)) u_filt (
    .sample(raw_cap_sample),
    .prev(filtered_cap_sample),
    .coef(raw_filter_coef),
    .result(filt_calc)
  );

  pxd_iir #(.W(W), .CW(CW)) u_base (
    .sample(filtered_cap_sample),
    .prev(env_baseline),
    .coef(filtered_cap_sample >= env_baseline ? baseline_pos_coef : baseline_neg_coef),
    .result(base_calc)
  );

  // After a compensation the filters restart from the new sample
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      raw_cap_sample <= '0;
      filtered_cap_sample <= '0;
      env_baseline <= '0;
      baseline_ref_r <= '0;
      user_delta <= '0;
      reinit_r <= 1'b1;
    end else begin
      if (comp_fin) reinit_r <= 1'b1;
      case (state_r)
        pxd_pkg::ST_CONV: if (afe_conv_done) raw_cap_sample <= afe_raw;
        pxd_pkg::ST_FILT: filtered_cap_sample <= reinit_r ? raw_cap_sample : filt_calc;
        pxd_pkg::ST_BASE: begin
          if (reinit_r) begin
            env_baseline <= filtered_cap_sample;
            baseline_ref_r <= filtered_cap_sample;
          end else if (!near_flag) begin
            env_baseline <= base_calc;
          end
        end
        pxd_pkg::ST_DIFF: user_delta <= sdiff(filtered_cap_sample, env_baseline);
        pxd_pkg::ST_STAT: reinit_r <= 1'b0;
        default: ;
      endcase
    end
  end

  // Drift since the last compensation, each side debounced
  assign drift = sdiff(env_baseline, baseline_ref_r);
  assign drift_req = state_r == pxd_pkg::ST_DIFF && !reinit_r &&
    ((drift > $signed({5'h00, baseline_pos_drift_limit}) &&
      pos_cnt_r >= baseline_pos_debounce) ||
     (-drift > $signed({5'h00, baseline_neg_drift_limit}) &&
      neg_cnt_r >= baseline_neg_debounce));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pos_cnt_r <= '0;
      neg_cnt_r <= '0;
    end else if (state_r == pxd_pkg::ST_DIFF) begin
      if (reinit_r || drift <= $signed({5'h00, baseline_pos_drift_limit})) begin
        pos_cnt_r <= '0;
      end else if (pos_cnt_r != '1) begin
        pos_cnt_r <= pos_cnt_r + NW'(1);
      end
      if (reinit_r || -drift <= $signed({5'h00, baseline_neg_drift_limit})) begin
        neg_cnt_r <= '0;
      end else if (neg_cnt_r != '1) begin
        neg_cnt_r <= neg_cnt_r + NW'(1);
      end
    end
  end

  // Near decision and op counters at the end of each operation
  assign near_nxt = user_delta > $signed({1'b0, thr_r});
  assign periodic_req = state_r == pxd_pkg::ST_STAT && periodic_comp_rate != '0 &&
    per_cnt_r + NW'(1) >= periodic_comp_rate;
  assign stuck_req = state_r == pxd_pkg::ST_STAT && near_nxt &&
    stuck_close_limit != '0 && stuck_cnt_r == stuck_close_limit;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      near_flag <= 1'b0;
      per_cnt_r <= '0;
      stuck_cnt_r <= '0;
    end else if (state_r == pxd_pkg::ST_STAT) begin
      near_flag <= near_nxt;
      per_cnt_r <= periodic_req ? '0 : per_cnt_r + NW'(1);
      if (!near_nxt) begin
        stuck_cnt_r <= '0;
      end else if (stuck_cnt_r != '1) begin
        stuck_cnt_r <= stuck_cnt_r + NW'(1);
      end
    end
  end

  assign comp_pending_flag = comp_pend_r;

  // One-cycle event pulses toward the interrupt controller
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      near_irq <= 1'b0;
      away_irq <= 1'b0;
      op_done_irq <= 1'b0;
      comp_done_irq <= 1'b0;
    end else begin
      near_irq <= state_r == pxd_pkg::ST_STAT && near_nxt && !near_flag &&
        ctrl_r[pxd_pkg::CTRL_NEAR_EN];
      away_irq <= state_r == pxd_pkg::ST_STAT && !near_nxt && near_flag &&
        !irq_source_select && ctrl_r[pxd_pkg::CTRL_AWAY_EN];
      op_done_irq <= state_r == pxd_pkg::ST_STAT && irq_source_select &&
        ctrl_r[pxd_pkg::CTRL_DONE_EN];
      comp_done_irq <= comp_fin && ctrl_r[pxd_pkg::CTRL_CDONE_EN];
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_post_conv;
    state_r == pxd_pkg::ST_FILT ##1 state_r == pxd_pkg::ST_BASE ##1
    state_r == pxd_pkg::ST_DIFF ##1 state_r == pxd_pkg::ST_STAT ##1
    state_r == pxd_pkg::ST_IDLE;
  endsequence

  a_startup_comp: assert property (startup_req |=> comp_pending_flag)
    else $error("enable did not request compensation");
  a_host_comp: assert property (host_req |=> comp_pending_flag)
    else $error("host request not pending");
  a_comp_hold: assert property (comp_pend_r && !comp_fin |=> comp_pend_r)
    else $error("pending flag dropped early");
  a_comp_first: assert property (state_r == pxd_pkg::ST_GRANT && adc_grant && comp_pend_r
    |=> afe_comp_start && !afe_conv_start)
    else $error("conversion before pending compensation");
  a_proc_order: assert property (state_r == pxd_pkg::ST_CONV && afe_conv_done
    |=> s_post_conv)
    else $error("processing order broken");
  a_base_freeze: assert property (state_r == pxd_pkg::ST_BASE && near_flag && !reinit_r
    |=> $stable(env_baseline))
    else $error("baseline moved while near");
  a_delta_calc: assert property (state_r == pxd_pkg::ST_DIFF
    |=> user_delta == sdiff(filtered_cap_sample, env_baseline))
    else $error("delta mismatch");
  a_zero_scan: assert property (state_r == pxd_pkg::ST_IDLE && !scan_on
    |=> state_r == pxd_pkg::ST_IDLE)
    else $error("operation with zero interval");
  a_far_muted: assert property (irq_source_select && $stable(irq_source_select)
    |-> !away_irq)
    else $error("away event with select one");
  a_pen_block: assert property (state_r == pxd_pkg::ST_IDLE && pen_contact &&
    !host_driven_mode |=> state_r == pxd_pkg::ST_IDLE)
    else $error("scan during pen contact");
endmodule
`default_nettype wire

// ===== design/pxd_tick_gen.sv
// Scan wake-up tick generator: interval times a base unit of cycles.
// Interval of zero stops the counters and emits no tick.
`timescale 1ns/1ps
`default_nettype none
module pxd_tick_gen #(
  parameter int UNIT_CYCLES = pxd_pkg::SCAN_UNIT_CYCLES,
  parameter int IW = pxd_pkg::SCAN_W
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Control
  input wire logic [IW-1:0] interval,
  // Wake-up pulse
  output logic tick
);
  localparam int UW = $clog2(UNIT_CYCLES + 1);
  logic [UW-1:0] unit_cnt_r;
  logic [IW-1:0] per_cnt_r;
  logic unit_end;
  logic per_end;

  assign unit_end = unit_cnt_r == UW'(UNIT_CYCLES - 1);
  assign per_end = per_cnt_r + IW'(1) >= interval;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      unit_cnt_r <= '0;
      per_cnt_r <= '0;
      tick <= 1'b0;
    end else if (interval == '0) begin
      unit_cnt_r <= '0;
      per_cnt_r <= '0;
      tick <= 1'b0;
    end else begin
      unit_cnt_r <= unit_end ? '0 : unit_cnt_r + UW'(1);
      if (unit_end) begin
        per_cnt_r <= per_end ? '0 : per_cnt_r + IW'(1);
      end
      tick <= unit_end && per_end;
    end
  end
endmodule
`default_nettype wire

// ===== verif/pxd_afe_model.sv
// Behavioural AFE and ADC arbiter facing the proximity core.
// Assumes one-cycle start pulses; answers fast or slow as the bench asks.
`timescale 1ns/1ps
`default_nettype none
module pxd_afe_model (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Core requests
  input wire logic adc_req,
  input wire logic afe_comp_start,
  input wire logic afe_conv_start,
  // Answers
  output logic adc_grant,
  output logic afe_comp_done,
  output logic afe_conv_done,
  output logic [11:0] afe_raw,
  // Bench control
  input wire logic slow,
  input wire logic [11:0] raw_val
);
  int wait_n = 0;
  logic conv_r = 1'b0;
  logic grant_r = 1'b0;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_n <= 0;
      conv_r <= 1'b0;
      grant_r <= 1'b0;
    end else begin
      grant_r <= adc_req;
      if (afe_comp_start || afe_conv_start) begin
        wait_n <= slow ? 40 : 3;
        conv_r <= afe_conv_start;
      end else if (wait_n > 0) begin
        wait_n <= wait_n - 1;
      end
    end
  end
  assign adc_grant = grant_r;
  assign afe_comp_done = wait_n == 1 && !conv_r;
  assign afe_conv_done = wait_n == 1 && conv_r;
  // Sample valid only with its done pulse, so a stale capture shows up
  assign afe_raw = afe_conv_done ? raw_val : ~raw_val;
endmodule
`default_nettype wire

// ===== verif/pxd_prox_core_test.sv
// Self-checking bench: APB master, AFE model, event counters, read scoreboard.
// Assumes the zero-wait APB of the core and a scan unit shortened to 20 cycles.
`timescale 1ns/1ps
`default_nettype none
module pxd_prox_core_test;
  typedef struct {logic [7:0] a; logic [31:0] e; logic er;} pxd_note_type;
  pxd_note_type q[$];
  pxd_note_type n;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic host_driven_mode = 1'b0, touch_detect_mode = 1'b1, touch_trigger_mode = 1'b0;
  logic pen_contact = 1'b0, convert_cmd = 1'b0, chan_selected = 1'b0, slow = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, seed = 32'hA82424FC, prdata;
  logic [11:0] raw_val = 12'h000, raw, afe_raw;
  logic pready, pslverr, touch_conv_start, adc_req, adc_grant, afe_comp_start, afe_conv_start;
  logic afe_comp_done, afe_conv_done, near_irq, away_irq, op_done_irq, comp_done_irq;
  logic near_flag, comp_pending_flag, conversion_active_flag, conv_prev = 1'b0;
  logic [7:0] ev;
  int cnt[8], base[8], n_fail = 0, checked = 0, cyc = 0;

  pxd_prox_core #(.SCAN_UNIT_CYCLES(20)) i_pxd_prox_core (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .host_driven_mode,
    .touch_detect_mode, .touch_trigger_mode, .pen_contact, .convert_cmd, .chan_selected,
    .touch_conv_start, .adc_req, .adc_grant, .afe_comp_start, .afe_conv_start,
    .afe_comp_done, .afe_conv_done, .afe_raw, .near_irq, .away_irq, .op_done_irq,
    .comp_done_irq, .near_flag, .comp_pending_flag, .conversion_active_flag);
  pxd_afe_model i_pxd_afe_model (.pclk, .presetn, .adc_req, .afe_comp_start,
    .afe_conv_start, .adc_grant, .afe_comp_done, .afe_conv_done, .afe_raw, .slow, .raw_val);

  always #4 pclk = ~pclk;

  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", s, e, g);
    end
  endtask

  task automatic chk_cnt(input int i, input int e);
    chk($sformatf("event %0d", i), 32'(e), 32'(cnt[i] - base[i]));
  endtask

  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [31:0] e, input logic er);
    if (!w) q.push_back('{a, e, er});
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0, e, 1'b0);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 32'h0, 1'b0);
  endtask

  task automatic cmd(input logic pen, input logic ch);
    pen_contact <= pen;
    chan_selected <= ch;
    convert_cmd <= 1'b1;
    @(posedge pclk);
    convert_cmd <= 1'b0;
    repeat (60) @(posedge pclk);
  endtask

  // Counters settle on the negative edge, clear of the updates at the rising one
  task automatic wait_ops(input int k);
    int t;
    t = cnt[7] + k;
    for (int i = 0; i < 3000 && cnt[7] < t; i++) @(negedge pclk);
    if (cnt[7] < t) chk("operations", 32'(t), 32'(cnt[7]));
    @(posedge pclk);
  endtask

  task automatic endt(input string s);
    $display("test %s done", s);
    base = cnt;
  endtask

  always @(posedge pclk) begin
    cyc++;
    ev = {conv_prev & ~conversion_active_flag, touch_conv_start, comp_done_irq, op_done_irq,
          away_irq, near_irq, afe_comp_start, afe_conv_start};
    conv_prev = conversion_active_flag;
    for (int i = 0; i < 8; i++) cnt[i] += int'(ev[i]);
    if (afe_conv_start || afe_comp_start) chk("adc_req", 32'h1, 32'(adc_req));
    if (psel && penable && pready && !pwrite) begin
      if (q.size() == 0) chk("read note", 32'h0, 32'h1);
      else begin
        n = q.pop_front();
        chk($sformatf("read %h", n.a), n.e, prdata);
        chk($sformatf("error %h", n.a), 32'(n.er), 32'(pslverr));
      end
    end
    if (cyc == 20000) begin
      n_fail++;
      complete_run;
    end
  end

  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(pxd_pkg::ADDR_FILT, 32'(pxd_pkg::FILT_RST));
    rd(pxd_pkg::ADDR_THR, 32'(pxd_pkg::THR_RST));
    rd(pxd_pkg::ADDR_DRIFT, 32'(pxd_pkg::DRIFT_RST));
    rd(pxd_pkg::ADDR_STAT, 32'h0);
    apb(1'b0, 8'h24, 32'h0, 32'h0, 1'b1);
    endt("reset values");
    raw = 12'(rnd() & 32'h7FF);
    raw_val <= raw;
    pen_contact <= 1'b1;
    wr(pxd_pkg::ADDR_FILT, 32'h0000_0FF0);
    wr(pxd_pkg::ADDR_CTRL, 32'h0000_0082);
    rd(pxd_pkg::ADDR_STAT, 32'h2);
    repeat (100) @(posedge pclk);
    chk_cnt(0, 0);
    pen_contact <= 1'b0;
    wait_ops(1);
    touch_detect_mode <= 1'b0;
    host_driven_mode <= 1'b1;
    chk_cnt(1, 1);
    chk_cnt(5, 1);
    rd(pxd_pkg::ADDR_SAMP, {4'h0, raw, 4'h0, raw});
    rd(pxd_pkg::ADDR_BASE, {20'h0, raw});
    rd(pxd_pkg::ADDR_STAT, 32'h0);
    endt("startup compensation");
    wr(pxd_pkg::ADDR_CTRL, 32'h0000_0181);
    rd(pxd_pkg::ADDR_STAT, 32'h2);
    chk("comp_pending_flag", 32'h1, 32'(comp_pending_flag));
    cmd(1'b0, 1'b0);
    chk_cnt(1, 1);
    rd(pxd_pkg::ADDR_STAT, 32'h0);
    endt("host compensation");
    wr(pxd_pkg::ADDR_CTRL, 32'h0000_0031);
    raw_val <= raw + 12'h200;
    cmd(1'b0, 1'b0);
    rd(pxd_pkg::ADDR_BASE, {3'h0, 13'h1E0, 4'h0, raw + 12'h020});
    rd(pxd_pkg::ADDR_STAT, 32'h1);
    chk("near_flag", 32'h1, 32'(near_flag));
    cmd(1'b0, 1'b0);
    rd(pxd_pkg::ADDR_BASE, {3'h0, 13'h1E0, 4'h0, raw + 12'h020});
    raw_val <= raw;
    cmd(1'b0, 1'b0);
    rd(pxd_pkg::ADDR_BASE, {3'h0, 13'h1FE0, 4'h0, raw + 12'h020});
    chk_cnt(2, 1);
    chk_cnt(3, 1);
    chk_cnt(6, 0);
    wr(pxd_pkg::ADDR_THR, 32'h0000_01C2);
    raw_val <= raw + 12'h200;
    cmd(1'b0, 1'b0);
    rd(pxd_pkg::ADDR_BASE, {3'h0, 13'h1C2, 4'h0, raw + 12'h03E});
    rd(pxd_pkg::ADDR_STAT, 32'h0);
    endt("near and away");
    // Rate one asks after every op, so the phase of the op counter does not matter
    wr(pxd_pkg::ADDR_COMP, 32'h0000_0001);
    repeat (2) cmd(1'b0, 1'b0);
    wr(pxd_pkg::ADDR_COMP, 32'h0000_0002);
    repeat (3) cmd(1'b0, 1'b0);
    chk_cnt(1, 3);
    wr(pxd_pkg::ADDR_COMP, 32'h0000_0000);
    endt("periodic compensation");
    cmd(1'b1, 1'b0);
    chk_cnt(6, 1);
    chk_cnt(0, 1);
    cmd(1'b1, 1'b1);
    chk_cnt(0, 1);
    wr(pxd_pkg::ADDR_CTRL, 32'h0000_0000);
    cmd(1'b1, 1'b0);
    chk_cnt(6, 3);
    chk_cnt(0, 1);
    endt("host convert");
    slow <= 1'b1;
    pen_contact <= 1'b0;
    host_driven_mode <= 1'b0;
    touch_trigger_mode <= 1'b1;
    wr(pxd_pkg::ADDR_CTRL, 32'h0000_0069);
    wait_ops(3);
    chk_cnt(4, cnt[7] - base[7]);
    chk_cnt(0, cnt[7] - base[7]);
    chk_cnt(3, 0);
    endt("operation done select");
    complete_run;
  end
endmodule
`default_nettype wire
